// file: logic/rso_defs.vh
// Constants for the receive status output block
`ifndef RSO_DEFS_VH
`define RSO_DEFS_VH
`define RSO_NCH        8
`define RSO_WORD_W     3
`define RSO_BIT_NEG    0
`define RSO_BIT_POS    1
`define RSO_BIT_LOS    2
`define RSO_BUF_DEPTH  2
`define RSO_CNT_W      2
`define RSO_WORD_RST   3'h0
`endif

// file: logic/rso_buf.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "rso_defs.vh"
module rso_buf #(
  parameter WIDTH = `RSO_WORD_W
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_b,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [`RSO_CNT_W-1:0] FULL_CNT = `RSO_BUF_DEPTH;
  localparam [`RSO_CNT_W-1:0] ONE_CNT  = 2'h1;

  reg [WIDTH-1:0]      mem_reg [0:1];
  reg                  wr_ptr_reg;
  reg                  rd_ptr_reg;
  reg [`RSO_CNT_W-1:0] count_reg;
  reg [`RSO_CNT_W-1:0] count_next;
  reg                  ready_reg;
  wire                 push;
  wire                 pop;

  assign push      = in_valid && ready_reg;
  assign pop       = out_valid && out_ready;
  assign in_ready  = ready_reg;
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];

  always @* begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + ONE_CNT;
    end else if (pop && !push) begin
      count_next = count_reg - ONE_CNT;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_reg[0] <= {WIDTH{1'b0}};
      mem_reg[1] <= {WIDTH{1'b0}};
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
      ready_reg  <= 1'b1;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_next;
      ready_reg <= (count_next != FULL_CNT);
    end
  end
endmodule

// file: logic/rso_top.v
// Eight-channel receive status and data output logic
`timescale 1ns/1ps
`include "rso_defs.vh"
module rso_top #(
  parameter NCH = `RSO_NCH
) (
  // Core clock and reset
  input  wire           CORE_CLK,
  input  wire           RST_B,
  // Mode pins, shared by all channels
  input  wire           SINGLE_RAIL,
  input  wire           AMI_SELECT,
  input  wire           RX_MUTE_CONTROL,
  input  wire           RX_CLOCK_EDGE_SELECT,
  // Recovered line side, per channel
  input  wire [NCH-1:0] RECOVERED_CLK,
  input  wire [NCH-1:0] RECOVERED_POS,
  input  wire [NCH-1:0] RECOVERED_NEG,
  input  wire [NCH-1:0] LOSS_DETECT,
  // Framer side, per channel
  input  wire [NCH-1:0] FRAMER_READY,
  output wire [NCH-1:0] RX_ACCEPT,
  output wire [NCH-1:0] RX_CLK_OUT,
  output wire [NCH-1:0] POSITIVE_RAIL_OUT,
  output wire [NCH-1:0] NEGATIVE_RAIL_OUT,
  output wire [NCH-1:0] LOSS_OF_SIGNAL_FLAG
);
  // Mode pin synchronisers
  reg  [3:0] mode_s1_reg;
  reg  [3:0] mode_s2_reg;
  wire       single_rail;
  wire       ami_sel;
  wire       rx_mute_control;
  wire       rx_clock_edge_select;

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_s1_reg <= 4'h0;
      mode_s2_reg <= 4'h0;
    end else begin
      mode_s1_reg <= {RX_CLOCK_EDGE_SELECT, RX_MUTE_CONTROL, AMI_SELECT, SINGLE_RAIL};
      mode_s2_reg <= mode_s1_reg;
    end
  end

  assign single_rail          = mode_s2_reg[0];
  assign ami_sel              = mode_s2_reg[1];
  assign rx_mute_control      = mode_s2_reg[2];
  assign rx_clock_edge_select = mode_s2_reg[3];

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
      reg                    clk_s1_reg;
      reg                    clk_s2_reg;
      reg                    clk_s3_reg;
      reg  [2:0]             dat_s1_reg;
      reg  [2:0]             dat_s2_reg;
      reg                    last_pol_reg;
      reg                    seen_mark_reg;
      reg                    fr_s1_reg;
      reg                    fr_s2_reg;
      reg                    rclk_reg;
      reg                    pos_reg;
      reg                    neg_reg;
      reg                    los_reg;
      reg                    code_violation_flag;
      reg  [`RSO_WORD_W-1:0] word;
      wire                   rise;
      wire                   fall;
      wire                   upd;
      wire                   pos_in;
      wire                   neg_in;
      wire                   los_in;
      wire                   mark;
      wire                   muted;
      wire                   buf_valid;
      wire [`RSO_WORD_W-1:0] buf_data;
      wire                   pop;

      // Two flip-flops ahead of any logic, third stage for edges
      always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
          clk_s1_reg <= 1'b0;
          clk_s2_reg <= 1'b0;
          clk_s3_reg <= 1'b0;
          dat_s1_reg <= 3'h0;
          dat_s2_reg <= 3'h0;
          fr_s1_reg  <= 1'b0;
          fr_s2_reg  <= 1'b0;
        end else begin
          clk_s1_reg <= RECOVERED_CLK[ch];
          clk_s2_reg <= clk_s1_reg;
          clk_s3_reg <= clk_s2_reg;
          dat_s1_reg <= {LOSS_DETECT[ch], RECOVERED_POS[ch], RECOVERED_NEG[ch]};
          dat_s2_reg <= dat_s1_reg;
          fr_s1_reg  <= FRAMER_READY[ch];
          fr_s2_reg  <= fr_s1_reg;
        end
      end

      assign rise   = clk_s2_reg && !clk_s3_reg;
      assign fall   = !clk_s2_reg && clk_s3_reg;
      assign neg_in = dat_s2_reg[0];
      assign pos_in = dat_s2_reg[1];
      assign los_in = dat_s2_reg[2];
      assign mark   = pos_in ^ neg_in;
      assign muted  = rx_mute_control && los_in;

      // Violation check on each recovered bit
      always @* begin
        code_violation_flag = 1'b0;
        if (pos_in && neg_in) begin
          code_violation_flag = 1'b1;
        end else if (ami_sel && mark && seen_mark_reg && (pos_in == last_pol_reg)) begin
          code_violation_flag = 1'b1;
        end
      end

      always @* begin
        word = `RSO_WORD_RST;
        word[`RSO_BIT_LOS] = los_in;
        if (!muted) begin
          word[`RSO_BIT_POS] = single_rail ? (pos_in | neg_in) : pos_in;
          word[`RSO_BIT_NEG] = single_rail ? code_violation_flag : neg_in;
        end
      end

      // Polarity of the last mark, for bipolar violations
      always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
          last_pol_reg  <= 1'b0;
          seen_mark_reg <= 1'b0;
        end else if (rise && mark) begin
          last_pol_reg  <= pos_in;
          seen_mark_reg <= 1'b1;
        end
      end

      rso_buf #(
        .WIDTH (`RSO_WORD_W)
      ) u_buf (
        .clk       (CORE_CLK),
        .rst_b     (RST_B),
        .in_valid  (rise),
        .in_ready  (RX_ACCEPT[ch]),
        .in_data   (word),
        .out_valid (buf_valid),
        .out_ready (upd && fr_s2_reg),
        .out_data  (buf_data)
      );

      assign upd = rx_clock_edge_select ? fall : rise;
      assign pop = upd && fr_s2_reg && buf_valid;

      // Output flops, one update per recovered clock period
      always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
          rclk_reg <= 1'b0;
          pos_reg  <= 1'b0;
          neg_reg  <= 1'b0;
          los_reg  <= 1'b0;
        end else begin
          rclk_reg <= clk_s2_reg;
          if (pop) begin
            pos_reg <= buf_data[`RSO_BIT_POS];
            neg_reg <= buf_data[`RSO_BIT_NEG];
            los_reg <= buf_data[`RSO_BIT_LOS];
          end
        end
      end

      assign RX_CLK_OUT[ch]          = rclk_reg;
      assign POSITIVE_RAIL_OUT[ch]   = pos_reg;
      assign NEGATIVE_RAIL_OUT[ch]   = neg_reg;
      assign LOSS_OF_SIGNAL_FLAG[ch] = los_reg;
    end
  endgenerate
endmodule

// file: bench/rso_chk_sva.sv
// Checker on channel zero of the receive outputs
`timescale 1ns/1ps
module rso_chk #(
  parameter NCH = 8
) (
  // Clock, reset, modes
  input wire           CORE_CLK,
  input wire           RST_B,
  input wire           SINGLE_RAIL,
  input wire           RX_MUTE_CONTROL,
  input wire           RX_CLOCK_EDGE_SELECT,
  // Line and framer side
  input wire [NCH-1:0] RECOVERED_CLK,
  input wire [NCH-1:0] FRAMER_READY,
  input wire [NCH-1:0] RX_ACCEPT,
  input wire [NCH-1:0] RX_CLK_OUT,
  input wire [NCH-1:0] POSITIVE_RAIL_OUT,
  input wire [NCH-1:0] NEGATIVE_RAIL_OUT,
  input wire [NCH-1:0] LOSS_OF_SIGNAL_FLAG
);
  wire [2:0] out0 = {LOSS_OF_SIGNAL_FLAG[0], POSITIVE_RAIL_OUT[0], NEGATIVE_RAIL_OUT[0]};
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  clk_copy_a: assert property (
    RX_CLK_OUT[0] == $past(RECOVERED_CLK[0], 3)) else $error("clock copy lag");
  upd_rise_a: assert property (
    !RX_CLOCK_EDGE_SELECT && !$past(RX_CLOCK_EDGE_SELECT, 4) && $changed(out0) |-> $rose(RX_CLK_OUT[0]))
    else $error("update off rise");
  upd_fall_a: assert property (
    RX_CLOCK_EDGE_SELECT && $past(RX_CLOCK_EDGE_SELECT, 4) && $changed(out0) |-> $fell(RX_CLK_OUT[0]))
    else $error("update off fall");
  los_hold_a: assert property (
    $rose(LOSS_OF_SIGNAL_FLAG[0]) |-> LOSS_OF_SIGNAL_FLAG[0] [*8]) else $error("loss flag short");
  cv_pulse_a: assert property (
    SINGLE_RAIL && $rose(NEGATIVE_RAIL_OUT[0]) |-> NEGATIVE_RAIL_OUT[0] [*8]) else $error("violation short");
  mute_low_a: assert property (
    RX_MUTE_CONTROL && $past(RX_MUTE_CONTROL, 8) && LOSS_OF_SIGNAL_FLAG[0] |-> out0[1:0] == 2'h0)
    else $error("mute failed");
  stall_hold_a: assert property (
    (!FRAMER_READY[0]) [*4] |=> $stable(out0)) else $error("output moved in stall");
  accept_rise_a: assert property (
    $rose(RX_ACCEPT[0]) |-> $past(FRAMER_READY[0], 3) || $past(FRAMER_READY[0], 4)) else $error("accept rose");
endmodule
bind rso_top rso_chk #(.NCH(NCH)) chk_u (.CORE_CLK, .RST_B, .SINGLE_RAIL, .RX_MUTE_CONTROL, .RX_CLOCK_EDGE_SELECT,
  .RECOVERED_CLK, .FRAMER_READY, .RX_ACCEPT, .RX_CLK_OUT, .POSITIVE_RAIL_OUT, .NEGATIVE_RAIL_OUT,
  .LOSS_OF_SIGNAL_FLAG);

// file: bench/rso_framer.sv
// Framer model for channel zero
`timescale 1ns/1ps
module rso_framer (
  // Bench control
  input  wire logic       stall,
  input  wire logic       edge_sel,
  // Receive side
  input  wire logic       rclk,
  input  wire logic [2:0] word,
  output wire logic       ready
);
  logic [2:0] got[$];
  assign ready = !stall;
  // Sample half a period away from the update edge
  always @(rclk) begin
    if (rclk === edge_sel) begin
      got.push_back(word);
    end
  end
endmodule

// file: bench/tb_top.sv
// Bench for the receive status outputs
`timescale 1ns/1ps
module tb_top;
  logic       clk = 0, rst_b = 0, sr = 0, ami = 0, mute = 1, es = 1, stall = 0;
  logic       lc = 0, lp = 0, ln = 0, ll = 0;
  wire  [7:0] acc, rco, po, no, lo;
  wire        r0;
  int         bad_count = 0, n_checks = 0, lastm = 0;
  always #4 clk = ~clk;
  rso_top dut_u (.CORE_CLK(clk), .RST_B(rst_b), .SINGLE_RAIL(sr), .AMI_SELECT(ami), .RX_MUTE_CONTROL(mute),
    .RX_CLOCK_EDGE_SELECT(es), .RECOVERED_CLK({8{lc}}), .RECOVERED_POS({8{lp}}), .RECOVERED_NEG({8{ln}}),
    .LOSS_DETECT({8{ll}}), .FRAMER_READY({8{r0}}), .RX_ACCEPT(acc), .RX_CLK_OUT(rco), .POSITIVE_RAIL_OUT(po),
    .NEGATIVE_RAIL_OUT(no), .LOSS_OF_SIGNAL_FLAG(lo));
  rso_framer fr_u (.stall(stall), .edge_sel(es), .rclk(rco[0]), .word({lo[0], po[0], no[0]}), .ready(r0));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One line period of 8 core cycles, word as {loss, pos, neg}
  task automatic bit1(input logic [2:0] w);
    @(negedge clk);
    {ll, lp, ln} = w;
    lc = 1;
    repeat (4) @(negedge clk);
    lc = 0;
    repeat (3) @(negedge clk);
  endtask
  // Eight words plus a pad; framer sample i+1 holds word i
  task automatic play(input string nm, input logic [23:0] s, input logic [3:0] m);
    logic [2:0] w;
    logic [2:0] e;
    {sr, ami, mute, es} = m;
    repeat (6) @(negedge clk);
    fr_u.got.delete();
    for (int i = 0; i < 9; i++) bit1(i < 8 ? s[3*i+:3] : 3'h0);
    for (int i = 0; i < 8; i++) begin
      w = s[3*i+:3];
      e = {w[2], w[1] | w[0], w[1] & w[0] | ami & (w[1] ^ w[0]) & (lastm == (w[1] ? 1 : 2))};
      if (w[1] ^ w[0]) lastm = w[1] ? 1 : 2;
      if (!sr) e[1:0] = w[1:0];
      if (mute & w[2]) e[1:0] = 2'h0;
      chk(nm, {5'h0, e}, {5'h0, fr_u.got[i + 1]});
    end
    chk({nm, " lanes pos"}, {8{po[0]}}, po);
    chk({nm, " lanes neg"}, {8{no[0]}}, no);
    chk({nm, " lanes loss"}, {8{lo[0]}}, lo);
    $display("Test %s done", nm);
  endtask
  // Full buffer refuses, held words come out in order
  task automatic t_stall;
    {sr, ami, mute, es} = 4'h0;
    stall = 1;
    repeat (6) @(negedge clk);
    for (int i = 0; i < 4; i++) bit1(i == 0 ? 3'h2 : 3'h1);
    chk("accept", 8'h00, acc);
    stall = 0;
    repeat (4) @(negedge clk);
    fr_u.got.delete();
    bit1(3'h0);
    bit1(3'h0);
    chk("kept pad", 8'h00, {5'h0, fr_u.got[0]});
    chk("kept word", 8'h02, {5'h0, fr_u.got[1]});
    $display("Test stall done");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1;
    play("dual fall", 24'h2d10ca, 4'h3);
    play("dual rise", 24'h2d10ca, 4'h2);
    play("single", 24'h299613, 4'ha);
    play("ami", 24'h488252, 4'he);
    play("muted loss", 24'h1cad2e, 4'h2);
    play("unmuted loss", 24'h1cad2e, 4'h0);
    t_stall();
    test_done();
  end
  // Run needs about 4.3 us; cut off well beyond
  initial begin
    #100000;
    bad_count++;
    test_done();
  end
endmodule
